// ===== ddr_ecc_error_reporting.sv
// DDR controller command issue, ECC check and error reporting
//
// The Wishbone interface to the registers and the address map were decided locally.
module ddr_ecc_error_reporting #(
    parameter int ADDR_W = 16,                 // Memory address width
    parameter int RANKS  = 2                   // Chip select count
) (
    input  wire logic              clk_i,      // Controller clock
    input  wire logic              rst_i,      // Sync reset, high
    input  wire logic              cyc_i,      // Wishbone cycle
    input  wire logic              stb_i,      // Wishbone strobe
    input  wire logic              we_i,       // Wishbone write
    input  wire logic [4:0]        adr_i,      // Wishbone byte address
    input  wire logic [3:0]        sel_i,      // Wishbone byte selects
    input  wire logic [31:0]       dat_i,      // Wishbone write data
    output logic      [31:0]       dat_o,      // Wishbone read data
    output logic                   ack_o,      // Wishbone acknowledge
    input  wire logic              rd_valid_i, // Read beat valid
    input  wire logic [63:0]       rd_data_i,  // Read beat data
    input  wire logic [7:0]        rd_check_i, // Read beat check bits
    output logic [ADDR_W-1:0]      mem_addr_lines_o,    // Address out
    output logic                   mem_addr_lines_oe_o, // Address drive
    output logic [RANKS-1:0]       rank_chip_select_n_o, // Selects
    output logic [RANKS-1:0]       rank_clock_enable_o, // Clock enables
    output logic [RANKS-1:0]       rank_termination_ctl_o, // ODT
    output logic [3:0]             burst_beats_o, // Configured burst
    output logic                   mem_if_enable_o, // Interface on
    output logic                   drive_strength_sel_o, // Drive select
    output logic                   core_fault_o, // Core fault pulse
    output logic                   irq_o       // Interrupt level
);
    localparam int RANK_W = (RANKS > 1) ? $clog2(RANKS) : 1;

    logic [31:0]            mem_cfg_r;
    logic                   multibit_detect_disable_r;
    logic [31:0]            int_en_r;
    logic [31:0]            status_r;
    logic [31:0]            status_nxt;
    logic [31:0]            evt_set;
    logic [31:0]            evt_clr;
    logic [ADDR_W-1:0]      cmd_addr_r;
    logic [RANK_W-1:0]      cmd_rank_r;
    logic                   cmd_pend_r;
    ddr_ecc_pkg::cmd_state_t state_r;
    logic                   wb_req;
    logic                   wb_wr;
    logic [31:0]            wmask;
    logic [31:0]            rdata;
    logic                   half_mode;
    logic                   ecc_en;
    logic                   odd_seen_r;
    logic [7:0]             part_r;
    logic [7:0]             chk_first;
    logic [7:0]             chk_second;
    logic [31:0]            second_in;
    logic [7:0]             syndrome;
    logic                   gran_done;
    logic                   multi_det;
    logic                   cmd_done;

    assign half_mode = mem_cfg_r[ddr_ecc_pkg::HALF_BIT];
    assign ecc_en    = mem_cfg_r[ddr_ecc_pkg::ECC_EN_BIT];

    // Bus handshake: one wait state, ack drops after one cycle
    assign wb_req = cyc_i && stb_i && !ack_o;
    assign wb_wr  = wb_req && we_i;
    assign wmask  = {{8{sel_i[3]}}, {8{sel_i[2]}},
                     {8{sel_i[1]}}, {8{sel_i[0]}}};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= wb_req;
        end
    end

    // Configuration register, byte lanes honoured
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mem_cfg_r <= ddr_ecc_pkg::MEM_CFG_RST;
        end else if (wb_wr && adr_i == ddr_ecc_pkg::OFF_MEM_CFG) begin
            mem_cfg_r <= (mem_cfg_r & ~wmask) | (dat_i & wmask);
        end
    end

    // Multi-bit detect disable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            multibit_detect_disable_r <= 1'b0;
        end else if (wb_wr && adr_i == ddr_ecc_pkg::OFF_ERR_DIS
                     && sel_i[3]) begin
            multibit_detect_disable_r <= dat_i[ddr_ecc_pkg::MULTI_BIT];
        end
    end

    // Interrupt enables, only event bits are kept
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_en_r <= 32'h0000_0000;
        end else if (wb_wr && adr_i == ddr_ecc_pkg::OFF_ERR_INTEN) begin
            int_en_r <= ((int_en_r & ~wmask) | (dat_i & wmask))
                        & ddr_ecc_pkg::EVT_MASK;
        end
    end

    // Command register: a write queues one command issue
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_addr_r <= '0;
            cmd_rank_r <= '0;
        end else if (wb_wr && adr_i == ddr_ecc_pkg::OFF_CMD
                     && !cmd_pend_r) begin
            cmd_addr_r <= dat_i[ADDR_W-1:0];
            cmd_rank_r <= dat_i[ddr_ecc_pkg::CMD_RANK_BIT +: RANK_W];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_pend_r <= 1'b0;
        end else if (state_r == ddr_ecc_pkg::ST_ISSUE) begin
            cmd_pend_r <= 1'b0;
        end else if (wb_wr && adr_i == ddr_ecc_pkg::OFF_CMD) begin
            cmd_pend_r <= 1'b1;
        end
    end

    // Issue sequence; the gap and idle cycles keep commands at least two cycles apart
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ddr_ecc_pkg::ST_IDLE;
        end else begin
            case (state_r)
                ddr_ecc_pkg::ST_IDLE: begin
                    if (cmd_pend_r && mem_if_enable_o) begin
                        state_r <= ddr_ecc_pkg::ST_ISSUE;
                    end
                end
                ddr_ecc_pkg::ST_ISSUE: state_r <= ddr_ecc_pkg::ST_GAP;
                ddr_ecc_pkg::ST_GAP:   state_r <= ddr_ecc_pkg::ST_IDLE;
                default:               state_r <= ddr_ecc_pkg::ST_IDLE;
            endcase
        end
    end
    assign cmd_done = (state_r == ddr_ecc_pkg::ST_ISSUE);

    // Pin stage: drive, address and select switch together
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mem_addr_lines_oe_o  <= 1'b0;
            mem_addr_lines_o     <= '0;
            rank_chip_select_n_o <= '1;
        end else if (state_r == ddr_ecc_pkg::ST_IDLE && cmd_pend_r
                     && mem_if_enable_o) begin
            mem_addr_lines_oe_o  <= 1'b1;
            mem_addr_lines_o     <= cmd_addr_r;
            rank_chip_select_n_o <= ~(RANKS'(1) << cmd_rank_r);
        end else begin
            mem_addr_lines_oe_o  <= 1'b0;
            mem_addr_lines_o     <= '0;
            rank_chip_select_n_o <= '1;
        end
    end

    // Rank clock enable and termination follow the interface enable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rank_clock_enable_o    <= '0;
            rank_termination_ctl_o <= '0;
            mem_if_enable_o        <= 1'b0;
            drive_strength_sel_o   <= 1'b0;
            burst_beats_o          <= ddr_ecc_pkg::BURST_4;
        end else begin
            mem_if_enable_o <= mem_cfg_r[ddr_ecc_pkg::MEM_EN_BIT];
            rank_clock_enable_o <=
                {RANKS{mem_cfg_r[ddr_ecc_pkg::MEM_EN_BIT]}};
            rank_termination_ctl_o <=
                {RANKS{mem_cfg_r[ddr_ecc_pkg::MEM_EN_BIT]}};
            drive_strength_sel_o <= mem_cfg_r[ddr_ecc_pkg::DRIVE_BIT];
            // Burst choice is software's; the block only obeys it
            burst_beats_o <= mem_cfg_r[ddr_ecc_pkg::EIGHT_BIT]
                             ? ddr_ecc_pkg::BURST_8
                             : ddr_ecc_pkg::BURST_4;
        end
    end

    // Two table halves; in half width the second half sees the low lane
    assign second_in = half_mode ? rd_data_i[31:0] : rd_data_i[63:32];

    ecc_half_check #(
        .ROW_BASE (ddr_ecc_pkg::ROWS_FIRST)
    ) u_first (
        .data_i  (rd_data_i[31:0]),
        .check_o (chk_first)
    );

    ecc_half_check #(
        .ROW_BASE (ddr_ecc_pkg::ROWS_SECOND)
    ) u_second (
        .data_i  (second_in),
        .check_o (chk_second)
    );

    // Half width: odd beat holds first-half bits, even beat finishes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            odd_seen_r <= 1'b0;
            part_r     <= 8'h00;
        end else if (rd_valid_i && half_mode) begin
            odd_seen_r <= !odd_seen_r;
            if (!odd_seen_r) begin
                part_r <= chk_first;
            end
        end else if (!half_mode) begin
            odd_seen_r <= 1'b0;
        end
    end

    always_comb begin
        if (half_mode) begin
            syndrome = part_r ^ chk_second ^ rd_check_i;
        end else begin
            syndrome = chk_first ^ chk_second ^ rd_check_i;
        end
    end

    // Even-weight nonzero syndrome means more than one flipped bit
    assign gran_done = rd_valid_i && (!half_mode || odd_seen_r);
    assign multi_det = gran_done && ecc_en && !multibit_detect_disable_r
                       && (syndrome != 8'h00) && !(^syndrome);

    // Core fault pulse on each uncorrectable granule
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_fault_o <= 1'b0;
        end else begin
            core_fault_o <= multi_det;
        end
    end

    // Sticky status: a set in the clear cycle survives
    always_comb begin
        evt_set = 32'h0000_0000;
        evt_set[ddr_ecc_pkg::MULTI_BIT]    = multi_det;
        evt_set[ddr_ecc_pkg::CMD_DONE_BIT] = cmd_done;
        evt_clr = 32'h0000_0000;
        if (wb_wr && adr_i == ddr_ecc_pkg::OFF_ERR_CLR) begin
            evt_clr = dat_i & wmask;
        end
        status_nxt = ((status_r & ~evt_clr) | evt_set)
                     & ddr_ecc_pkg::EVT_MASK;
        if (!ecc_en) begin
            status_nxt[ddr_ecc_pkg::MULTI_BIT] = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_r <= 32'h0000_0000;
        end else begin
            status_r <= status_nxt;
        end
    end

    // Interrupt level from the registered status and enables
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status_r & int_en_r);
        end
    end

    // Read mux; clear register and unmapped words read zero
    always_comb begin
        rdata = 32'h0000_0000;
        case (adr_i)
            ddr_ecc_pkg::OFF_MEM_CFG:   rdata = mem_cfg_r;
            ddr_ecc_pkg::OFF_ERR_DIS:
                rdata[ddr_ecc_pkg::MULTI_BIT] = multibit_detect_disable_r;
            ddr_ecc_pkg::OFF_ERR_INTEN: rdata = int_en_r;
            ddr_ecc_pkg::OFF_ERR_STAT:  rdata = status_r;
            ddr_ecc_pkg::OFF_CMD: begin
                rdata[ADDR_W-1:0] = cmd_addr_r;
                rdata[ddr_ecc_pkg::CMD_RANK_BIT +: RANK_W] = cmd_rank_r;
                rdata[ddr_ecc_pkg::CMD_BUSY_BIT] = cmd_pend_r;
            end
            default:                    rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (wb_req && !we_i) begin
            dat_o <= rdata;
        end
    end

    // Checks on the pins and the reporting path
    AST_ADDR_RELEASED: assert property (@(posedge clk_i)
        disable iff (rst_i)
        !mem_addr_lines_oe_o |-> mem_addr_lines_o == '0)
        else $error("address lines active while released");
    AST_CS_WITH_DRIVE: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (rank_chip_select_n_o != '1) |-> mem_addr_lines_oe_o
            && mem_addr_lines_o == $past(cmd_addr_r))
        else $error("chip select without valid address");
    AST_DRIVE_ONE_CYCLE: assert property (@(posedge clk_i)
        disable iff (rst_i)
        mem_addr_lines_oe_o |=> !mem_addr_lines_oe_o ##1 1'b1)
        else $error("address drive held past one command");
    AST_NO_FAULT_ECC_OFF: assert property (@(posedge clk_i)
        disable iff (rst_i)
        !$past(ecc_en) |-> !core_fault_o)
        else $error("fault reported with ecc disabled");
    AST_FAULT_CAUSE: assert property (@(posedge clk_i)
        disable iff (rst_i)
        $past(multi_det) |-> core_fault_o
            && status_r[ddr_ecc_pkg::MULTI_BIT])
        else $error("multi-bit error not reported");
    AST_DISABLE_HIDES: assert property (@(posedge clk_i)
        disable iff (rst_i)
        $past(multibit_detect_disable_r) |-> !core_fault_o)
        else $error("error reported while detect disabled");
    AST_IRQ_GATED: assert property (@(posedge clk_i)
        disable iff (rst_i)
        ($past(int_en_r) == 32'h0000_0000) |-> !irq_o)
        else $error("interrupt with all enables clear");
    AST_STICKY_HOLD: assert property (@(posedge clk_i)
        disable iff (rst_i)
        status_r[ddr_ecc_pkg::MULTI_BIT] && ecc_en && !evt_clr[28]
            |=> status_r[ddr_ecc_pkg::MULTI_BIT])
        else $error("multi-bit flag lost without clear");
    AST_IRQ_FOLLOWS: assert property (@(posedge clk_i)
        disable iff (rst_i)
        status_r[28] && int_en_r[28] |=> irq_o)
        else $error("interrupt missing for enabled flag");
    AST_HALF_PAIRS: assert property (@(posedge clk_i)
        disable iff (rst_i)
        half_mode && rd_valid_i && !odd_seen_r
            |=> odd_seen_r && part_r == $past(chk_first))
        else $error("odd beat not held for pairing");
    AST_ACK_PULSE: assert property (@(posedge clk_i)
        disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");

    COV_CMD: cover property (@(posedge clk_i) disable iff (rst_i)
        mem_addr_lines_oe_o);
    COV_MULTI_IRQ: cover property (@(posedge clk_i) disable iff (rst_i)
        core_fault_o ##1 irq_o);
    COV_HALF_ERR: cover property (@(posedge clk_i) disable iff (rst_i)
        half_mode && multi_det);
endmodule

// ===== ecc_half_check.sv
// Shared constants and the 32-bit half check-bit encoder
package ddr_ecc_pkg;
    // Register word offsets (byte addresses)
    localparam logic [4:0] OFF_MEM_CFG   = 5'h00;
    localparam logic [4:0] OFF_ERR_DIS   = 5'h04;
    localparam logic [4:0] OFF_ERR_INTEN = 5'h08;
    localparam logic [4:0] OFF_ERR_STAT  = 5'h0c;
    localparam logic [4:0] OFF_ERR_CLR   = 5'h10;
    localparam logic [4:0] OFF_CMD       = 5'h14;
    // Memory configuration fields
    localparam int MEM_EN_BIT    = 31;
    localparam int TYPE_MSB      = 26;
    localparam int TYPE_LSB      = 24;
    localparam int HALF_BIT      = 3;
    localparam int ECC_EN_BIT    = 2;
    localparam int EIGHT_BIT     = 4;
    localparam int DRIVE_BIT     = 5;
    // Error disable / enable / status fields
    localparam int MULTI_BIT     = 28;
    localparam int CMD_DONE_BIT  = 0;
    // Command register fields
    localparam int CMD_RANK_BIT  = 16;
    localparam int CMD_BUSY_BIT  = 31;
    // Reset value and event bit mask
    localparam logic [31:0] MEM_CFG_RST = 32'h0000_0000;
    localparam logic [31:0] EVT_MASK    = 32'h1000_0001;
    // Memory type codes
    localparam logic [2:0] TYPE_DDR1 = 3'h2;
    localparam logic [2:0] TYPE_DDR2 = 3'h3;
    // Burst lengths in beats
    localparam logic [3:0] BURST_4 = 4'h4;
    localparam logic [3:0] BURST_8 = 4'h8;
    // Syndrome table split
    localparam int ROWS_FIRST  = 0;
    localparam int ROWS_SECOND = 32;

    // Command issue states, Gray along idle -> issue -> gap
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ISSUE = 2'b01,
        ST_GAP   = 2'b11
    } cmd_state_t;

    // Syndrome row code: six index bits, their parity, and a one,
    // so every row has odd weight and two flips give even weight
    function automatic logic [7:0] row_code(input int r);
        logic [5:0] v;
        v = r[5:0];
        return {v, ^v, 1'b1};
    endfunction
endpackage

// Check bits of 32 data bits against one half of the syndrome table
module ecc_half_check #(
    parameter int ROW_BASE = 0                 // First table row used
) (
    input  wire logic [31:0] data_i,           // Data half
    output logic      [7:0]  check_o           // Check bits
);
    // Fold every set data bit's row code into the result
    always_comb begin
        check_o = 8'h00;
        for (int j = 0; j < 32; j++) begin
            if (data_i[j]) begin
                check_o = check_o ^ ddr_ecc_pkg::row_code(ROW_BASE + j);
            end
        end
    end
endmodule

// ===== mem_model.sv
// Memory-side model: read beat source and address bus observer
module mem_model (
    input  wire logic        clk_i,      // Controller clock
    input  wire logic [15:0] addr_i,     // Address from controller
    input  wire logic        addr_oe_i,  // Address drive enable
    input  wire logic [1:0]  cs_n_i,     // Rank selects, low active
    output logic             rd_valid_o, // Beat valid
    output logic [63:0]      rd_data_o,  // Beat data
    output logic [7:0]       rd_check_o, // Beat check bits
    output logic             viol_o      // Select seen on floating bus
);
    timeunit 1ns;
    timeprecision 1ns;
    wire [15:0] addr_wire;

    // Released lines float, no termination on the address bus
    assign addr_wire = addr_oe_i ? addr_i : 16'hzzzz;

    initial begin
        rd_valid_o = 1'b0;
        rd_data_o  = 64'h0;
        rd_check_o = 8'h00;
        viol_o     = 1'b0;
    end

    // A rank selected while the bus floats would latch garbage
    always @(posedge clk_i) begin
        if ((|(~cs_n_i)) === 1'b1 && (^addr_wire) === 1'bx) begin
            viol_o <= 1'b1;
        end
    end

    // One beat, then stale data inverted so it never passes as valid
    task automatic beat(input logic [63:0] d, input logic [7:0] c,
                        input int gap);
        rd_valid_o <= 1'b1;
        rd_data_o  <= d;
        rd_check_o <= c;
        @(posedge clk_i);
        rd_valid_o <= 1'b0;
        rd_data_o  <= ~d;
        rd_check_o <= ~c;
        repeat (gap) @(posedge clk_i);
    endtask
endmodule

// ===== testbench.sv
// Self-checking bench for the DDR error reporting block
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i  = 1'b0;
    logic [4:0]  adr_i = 5'h00;
    logic [3:0]  sel_i = 4'hf;
    logic [31:0] dat_i = 32'h0;
    logic        rd_valid_i;
    logic [63:0] rd_data_i;
    logic [7:0]  rd_check_i;
    logic [31:0] dat_o;
    logic        ack_o, oe, mem_en, drv, fault, irq, viol;
    logic [15:0] addr;
    logic [1:0]  cs_n, cke, odt;
    logic [3:0]  beats;
    logic        half = 1'b0;
    logic [31:0] rdq[$], cmdq[$], flq[$];
    int          fails = 0;
    int          cmp_count = 0;

    ddr_ecc_error_reporting #(.ADDR_W(16), .RANKS(2)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .rd_valid_i(rd_valid_i),
        .rd_data_i(rd_data_i), .rd_check_i(rd_check_i),
        .mem_addr_lines_o(addr), .mem_addr_lines_oe_o(oe),
        .rank_chip_select_n_o(cs_n), .rank_clock_enable_o(cke),
        .rank_termination_ctl_o(odt), .burst_beats_o(beats),
        .mem_if_enable_o(mem_en), .drive_strength_sel_o(drv),
        .core_fault_o(fault), .irq_o(irq));

    mem_model mdl (
        .clk_i(clk_i), .addr_i(addr), .addr_oe_i(oe), .cs_n_i(cs_n),
        .rd_valid_o(rd_valid_i), .rd_data_o(rd_data_i),
        .rd_check_o(rd_check_i), .viol_o(viol));

    always #10 clk_i = ~clk_i;

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Classic single cycle; on reads d is the expected data
    task automatic wb(input logic w, input logic [4:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        if (!w) rdq.push_back(d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= w ? d : 32'($urandom);
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50) chk("ack", 32'h1, 32'h0);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        @(posedge clk_i);
    endtask

    // Own check-bit reference: row code is index, its parity, a one
    function automatic logic [7:0] enc(input logic [63:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < 64; i++) begin
            if (d[i]) c ^= {i[5:0], ^i[5:0], 1'b1};
        end
        return c;
    endfunction

    // One granule with up to two flipped bits; -1 flips nothing
    task automatic gran(input int fa, input int fb, input logic ef);
        logic [63:0] d, bad;
        d = {32'($urandom), 32'($urandom)};
        bad = d;
        if (fa >= 0) bad[fa] = ~bad[fa];
        if (fb >= 0) bad[fb] = ~bad[fb];
        if (ef) flq.push_back(32'h1);
        if (half) begin
            mdl.beat({32'($urandom), bad[31:0]}, 8'($urandom), 2);
            mdl.beat({32'($urandom), bad[63:32]}, enc(d), 0);
        end else begin
            mdl.beat(bad, enc(d), $urandom_range(3, 0));
        end
        repeat (4) @(posedge clk_i);
    endtask

    // Outputs matched in arrival order against the queued notes
    always @(posedge clk_i) begin
        if (!rst_i && ack_o === 1'b1 && we_i === 1'b0) begin
            chk("read", rdq.size() > 0 ? rdq.pop_front() : 32'hx, dat_o);
        end
        if (!rst_i && oe === 1'b1) begin
            chk("command", cmdq.size() > 0 ? cmdq.pop_front() : 32'hx,
                {14'h0, cs_n, addr});
        end else if (!rst_i && cs_n !== 2'b11) begin
            chk("idle selects", 32'h3, {30'h0, cs_n});
        end
        if (!rst_i && fault === 1'b1) begin
            chk("fault", flq.size() > 0 ? flq.pop_front() : 32'h0, 32'h1);
        end
    end

    // Watchdog far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        close_out();
    end

    initial begin
        logic [31:0] cfg;
        logic [15:0] ca;
        void'($urandom(57));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("reset beats", 32'h4, {28'h0, beats});
        chk("reset irq", 32'h0, {31'h0, irq});
        wb(0, ddr_ecc_pkg::OFF_MEM_CFG, ddr_ecc_pkg::MEM_CFG_RST);
        wb(0, ddr_ecc_pkg::OFF_ERR_STAT, 32'h0);
        wb(1, 5'h1c, 32'($urandom));
        wb(0, 5'h1c, 32'h0);
        // Every type and width, burst as software must pick it
        for (int k = 0; k < 4; k++) begin
            cfg = 32'h0;
            cfg[26:24] = k[1] ? ddr_ecc_pkg::TYPE_DDR2
                              : ddr_ecc_pkg::TYPE_DDR1;
            cfg[3] = k[0];
            cfg[4] = !k[1] && k[0];
            cfg[2] = 1'b1;
            cfg[5] = 1'b0;
            wb(1, ddr_ecc_pkg::OFF_MEM_CFG, cfg);
            chk("burst", cfg[4] ? 32'h8 : 32'h4, {28'h0, beats});
            chk("interface off", 32'h0, {31'h0, mem_en});
            cfg[31] = 1'b1;
            wb(1, ddr_ecc_pkg::OFF_MEM_CFG, cfg);
            wb(0, ddr_ecc_pkg::OFF_MEM_CFG, cfg);
            chk("clock enables", 32'h3, {30'h0, cke});
            chk("termination", 32'h3, {30'h0, odt});
            chk("interface on", 32'h1, {31'h0, mem_en});
            chk("drive select", 32'h0, {31'h0, drv});
        end
        cfg[3] = 1'b0;
        wb(1, ddr_ecc_pkg::OFF_MEM_CFG, cfg);
        // Commands to both ranks with random addresses
        for (int k = 0; k < 4; k++) begin
            ca = 16'($urandom);
            cmdq.push_back({14'h0, k[0] ? 2'b01 : 2'b10, ca});
            wb(1, ddr_ecc_pkg::OFF_CMD, {15'h0, k[0], ca});
            repeat (3) @(posedge clk_i);
        end
        wb(0, ddr_ecc_pkg::OFF_ERR_STAT, 32'h1);
        wb(1, ddr_ecc_pkg::OFF_ERR_CLR, 32'h1);
        wb(0, ddr_ecc_pkg::OFF_ERR_STAT, 32'h0);
        // Masked error still flags, then unmasking raises the line
        wb(1, ddr_ecc_pkg::OFF_ERR_DIS, 32'h0);
        gran(0, 63, 1);
        chk("masked irq", 32'h0, {31'h0, irq});
        wb(1, ddr_ecc_pkg::OFF_ERR_INTEN, 32'h1000_0000);
        wb(0, ddr_ecc_pkg::OFF_ERR_STAT, 32'h1000_0000);
        chk("irq", 32'h1, {31'h0, irq});
        gran(-1, -1, 0);
        gran(5, -1, 0);
        chk("sticky irq", 32'h1, {31'h0, irq});
        wb(1, ddr_ecc_pkg::OFF_ERR_CLR, 32'h1000_0000);
        repeat (3) @(posedge clk_i);
        chk("cleared irq", 32'h0, {31'h0, irq});
        gran(3, 40, 1);
        chk("irq again", 32'h1, {31'h0, irq});
        wb(1, ddr_ecc_pkg::OFF_ERR_CLR, 32'h1000_0000);
        // Detection disabled, then check codes off
        wb(1, ddr_ecc_pkg::OFF_ERR_DIS, 32'h1000_0000);
        gran(1, 2, 0);
        wb(0, ddr_ecc_pkg::OFF_ERR_STAT, 32'h0);
        wb(1, ddr_ecc_pkg::OFF_ERR_DIS, 32'h0);
        cfg[2] = 1'b0;
        wb(1, ddr_ecc_pkg::OFF_MEM_CFG, cfg);
        gran(1, 2, 0);
        wb(0, ddr_ecc_pkg::OFF_ERR_STAT, 32'h0);
        chk("ecc off irq", 32'h0, {31'h0, irq});
        // Half width: odd beat low rows, even beat high rows
        cfg[2] = 1'b1;
        cfg[3] = 1'b1;
        cfg[4] = 1'b1;
        wb(1, ddr_ecc_pkg::OFF_MEM_CFG, cfg);
        half = 1'b1;
        gran(-1, -1, 0);
        gran(7, 45, 1);
        wb(0, ddr_ecc_pkg::OFF_ERR_STAT, 32'h1000_0000);
        chk("leftover notes", 32'h0, rdq.size() + cmdq.size() + flq.size());
        chk("floating select", 32'h0, {31'h0, viol});
        close_out();
    end
endmodule
